/* hw/vipc_ctrl.sv */
// vectored interrupt controller with group priority and an AXI4-Lite register port
// Behaviour
// - each maskable source has an enable bit, six per enable register.
// - bit 7 of enable register 0 is the global gate for all maskable sources.
// - a source is served only when gate and its own enable bit are set.
// - gate cleared when vectoring, set again on return from interrupt.
// - hardware reset is the non-maskable source, always on, highest rank.
// - six groups; group g holds sources g, g+6, g+12, g+18.
// - group level is two bits, one from each level register.
// - higher level wins among simultaneous requests.
// - at equal level, the lower source number wins.
// - non-external sources level-triggered by default; per-source edge mode selectable.
// - service starts 3 to 9 machine cycles after the request.
// - vector is 0003h plus eight per source number.
// - any enabled pending source raises the stop/idle release.
// - acceptance held off during writes to enable, level or power registers.
// - a request sets its flag, held until the core accepts.
// - flag of the served source clears on acceptance.
// - external sources 0,1,5,6,11 detect pin edges per edge select.
// - two pending registers show external flags to software.
// - edge select picks rising, falling or both; reset selects none.
// - running routine pre-empted only by a strictly higher level.
// - writing 0 to an external pending bit clears it.
`timescale 1ns/1ps

module vipc_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [23:0] src_req,
    input wire logic [4:0] ext_pin,
    input wire logic power_ctrl_wr,
    input wire logic irq_ack,
    input wire logic return_from_isr,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic stop_idle_release
);
    import vipc_pkg::*;

    vipc_state_t st_reg;
    vipc_state_t st_next;

    logic [23:0] enable_vec;
    logic [23:0] set_ev;
    logic [4:0] ext_ev;
    logic [1:0] lvl_of [VIPC_NSRC];
    logic [9:0] edge_sel;
    logic wr_fire;
    logic rd_fire;
    logic global_irq_gate;

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    // write address and data are taken together; no skid buffer needed
    assign wr_fire = aclken && s_axi_awvalid && s_axi_wvalid && (st_reg.wr == VIPC_WR_IDLE);
    assign rd_fire = aclken && s_axi_arvalid && (st_reg.rd == VIPC_RD_IDLE);
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_arready = rd_fire;
    assign s_axi_bvalid = (st_reg.wr == VIPC_WR_RESP);
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = (st_reg.rd == VIPC_RD_DATA);
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;

    // ----------------------------------------------------------------
    // per-source request detection
    // ----------------------------------------------------------------
    assign global_irq_gate = st_reg.en0[VIPC_GATE_BIT];
    assign enable_vec = {st_reg.en3[5:0], st_reg.en2[5:0],
                         st_reg.en1[5:0], st_reg.en0[5:0]};
    assign edge_sel = {st_reg.sel1[1:0], st_reg.sel0_hi[3:0], st_reg.sel0_lo[3:0]};

    genvar gk;
    generate
        for (gk = 0; gk < VIPC_NEXT; gk++) begin : g_ext
            logic rise;
            logic fall;
            assign rise = ext_pin[gk] && !st_reg.ext_prev[gk];
            assign fall = !ext_pin[gk] && st_reg.ext_prev[gk];
            // select code 00 means no edge at all, the reset value
            assign ext_ev[gk] = (edge_sel[2*gk] && rise) || (edge_sel[2*gk+1] && fall);
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < VIPC_NSRC; gi++) begin : g_src
            assign lvl_of[gi] = {st_reg.lvl_hi[gi % VIPC_NGRP],
                                 st_reg.lvl_lo[gi % VIPC_NGRP]};
            if (VIPC_NO_SRC_MASK[gi]) begin : g_none
                assign set_ev[gi] = 1'b0;
            end
            else if (VIPC_EXT_MASK[gi]) begin : g_pin
                assign set_ev[gi] = ext_ev[vipc_ext_slot(gi)];
            end
            else begin : g_per
                assign set_ev[gi] = st_reg.trig[gi] ?
                                    (src_req[gi] && !st_reg.prev_req[gi]) :
                                    src_req[gi];
            end
        end
    endgenerate

    assign stop_idle_release = |(st_reg.flag & enable_vec);
    assign irq_req = st_reg.offer;
    assign irq_vector = st_reg.vector;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] wbyte;
        logic [23:0] sw_clr;
        logic [23:0] hw_clr;
        logic hold_now;
        logic found;
        logic [4:0] best_src;
        logic [1:0] best_lvl;
        logic cur_valid;
        logic [1:0] cur_lvl;
        logic [23:0] elig;
        wbyte = s_axi_wdata[7:0];
        sw_clr = '0;
        hw_clr = '0;
        hold_now = power_ctrl_wr;
        found = 1'b0;
        best_src = '0;
        best_lvl = '0;
        cur_valid = 1'b0;
        cur_lvl = '0;
        elig = '0;
        st_next = st_reg;

        // bus write side
        if (st_reg.wr == VIPC_WR_RESP && s_axi_bready)
        begin
            st_next.wr = VIPC_WR_IDLE;
        end
        if (wr_fire)
        begin
            st_next.wr = VIPC_WR_RESP;
            st_next.bresp = VIPC_RESP_OKAY;
            case (s_axi_awaddr)
                VIPC_ADDR_EN0:
                begin
                    hold_now = 1'b1;
                    if (s_axi_wstrb[0])
                        st_next.en0 = wbyte & VIPC_MASK_EN0;
                end
                VIPC_ADDR_EN1:
                begin
                    hold_now = 1'b1;
                    if (s_axi_wstrb[0])
                        st_next.en1 = wbyte & VIPC_MASK_EN;
                end
                VIPC_ADDR_EN2:
                begin
                    hold_now = 1'b1;
                    if (s_axi_wstrb[0])
                        st_next.en2 = wbyte & VIPC_MASK_EN;
                end
                VIPC_ADDR_EN3:
                begin
                    hold_now = 1'b1;
                    if (s_axi_wstrb[0])
                        st_next.en3 = wbyte & VIPC_MASK_EN;
                end
                VIPC_ADDR_LVL_LO:
                begin
                    hold_now = 1'b1;
                    if (s_axi_wstrb[0])
                        st_next.lvl_lo = wbyte & VIPC_MASK_EN;
                end
                VIPC_ADDR_LVL_HI:
                begin
                    hold_now = 1'b1;
                    if (s_axi_wstrb[0])
                        st_next.lvl_hi = wbyte & VIPC_MASK_EN;
                end
                VIPC_ADDR_SEL0_LO:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        st_next.sel0_lo = wbyte & VIPC_MASK_SEL0;
                    end
                end
                VIPC_ADDR_SEL0_HI:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        st_next.sel0_hi = wbyte & VIPC_MASK_SEL0;
                    end
                end
                VIPC_ADDR_SEL1:
                begin
                    if (s_axi_wstrb[0])
                    begin
                        st_next.sel1 = wbyte & VIPC_MASK_SEL1;
                    end
                end
                VIPC_ADDR_PEND0:
                begin
                    // writing one has no effect; zero clears
                    if (s_axi_wstrb[0])
                    begin
                        sw_clr[0] = !wbyte[0];
                        sw_clr[1] = !wbyte[1];
                        sw_clr[5] = !wbyte[2];
                        sw_clr[6] = !wbyte[3];
                    end
                end
                VIPC_ADDR_PEND1:
                begin
                    if (s_axi_wstrb[0])
                        sw_clr[11] = !wbyte[0];
                end
                VIPC_ADDR_TRIG:
                begin
                    if (s_axi_wstrb[0])
                        st_next.trig[7:0] = s_axi_wdata[7:0];
                    if (s_axi_wstrb[1])
                        st_next.trig[15:8] = s_axi_wdata[15:8];
                    if (s_axi_wstrb[2])
                        st_next.trig[23:16] = s_axi_wdata[23:16];
                end
                VIPC_ADDR_STAT, VIPC_ADDR_FLAGS: st_next.bresp = VIPC_RESP_OKAY;
                default:
                begin
                    st_next.bresp = VIPC_RESP_SLVERR;
                end
            endcase
        end

        // bus read side
        if (st_reg.rd == VIPC_RD_DATA && s_axi_rready)
        begin
            st_next.rd = VIPC_RD_IDLE;
        end
        if (rd_fire)
        begin
            st_next.rd = VIPC_RD_DATA;
            st_next.rresp = VIPC_RESP_OKAY;
            st_next.rdata = '0;
            case (s_axi_araddr)
                VIPC_ADDR_EN0: st_next.rdata[7:0] = st_reg.en0;
                VIPC_ADDR_EN1: st_next.rdata[7:0] = st_reg.en1;
                VIPC_ADDR_EN2: st_next.rdata[7:0] = st_reg.en2;
                VIPC_ADDR_EN3: st_next.rdata[7:0] = st_reg.en3;
                VIPC_ADDR_LVL_LO: st_next.rdata[7:0] = st_reg.lvl_lo;
                VIPC_ADDR_LVL_HI: st_next.rdata[7:0] = st_reg.lvl_hi;
                VIPC_ADDR_SEL0_LO: st_next.rdata[7:0] = st_reg.sel0_lo;
                VIPC_ADDR_SEL0_HI: st_next.rdata[7:0] = st_reg.sel0_hi;
                VIPC_ADDR_SEL1: st_next.rdata[7:0] = st_reg.sel1;
                VIPC_ADDR_PEND0: st_next.rdata[3:0] = {st_reg.flag[6], st_reg.flag[5],
                                                       st_reg.flag[1], st_reg.flag[0]};
                VIPC_ADDR_PEND1: st_next.rdata[0] = st_reg.flag[11];
                VIPC_ADDR_TRIG: st_next.rdata[23:0] = st_reg.trig;
                VIPC_ADDR_FLAGS: st_next.rdata[23:0] = st_reg.flag;
                VIPC_ADDR_STAT: st_next.rdata[12:0] = {global_irq_gate, st_reg.offer_lvl,
                                                       st_reg.offer_src, st_reg.offer,
                                                       st_reg.in_service};
                default: st_next.rresp = VIPC_RESP_SLVERR;
            endcase
        end

        // core accepts the offered vector
        if (st_reg.offer && irq_ack)
        begin
            hw_clr[st_reg.offer_src] = 1'b1;
            st_next.en0[VIPC_GATE_BIT] = 1'b0;
            st_next.in_service[st_reg.offer_lvl] = 1'b1;
            st_next.offer = 1'b0;
        end
        else if (st_reg.offer && (!global_irq_gate || !st_reg.flag[st_reg.offer_src]))
        begin
            // withdrawn if software closed the gate or cleared the flag first
            st_next.offer = 1'b0;
        end

        // return: reopen the gate and retire the highest active level
        if (return_from_isr)
        begin
            st_next.en0[VIPC_GATE_BIT] = 1'b1;
            for (int l = 0; l < 4; l++)
            begin
                if (st_reg.in_service[l])
                begin
                    cur_lvl = 2'(l);
                end
            end
            st_next.in_service[cur_lvl] = 1'b0;
        end

        // flags: an arriving request beats a clear in the same cycle
        st_next.flag = ((st_reg.flag & ~(sw_clr | hw_clr)) | set_ev) & ~VIPC_NO_SRC_MASK;
        st_next.prev_req = src_req;
        st_next.ext_prev = ext_pin;
        st_next.hold = hold_now;

        // arbitration: descending scan with >= lets the lower number win ties
        elig = st_reg.flag & enable_vec;
        for (int i = VIPC_NSRC - 1; i >= 0; i--)
        begin
            if (elig[i] && (!found || lvl_of[i] >= best_lvl))
            begin
                found = 1'b1;
                best_src = 5'(i);
                best_lvl = lvl_of[i];
            end
        end
        cur_lvl = '0;
        for (int l = 0; l < 4; l++)
        begin
            if (st_reg.in_service[l])
            begin
                cur_valid = 1'b1;
                cur_lvl = 2'(l);
            end
        end
        if (!st_reg.offer && found && global_irq_gate && !hold_now && !st_reg.hold
            && (!cur_valid || best_lvl > cur_lvl))
        begin
            st_next.offer = 1'b1;
            st_next.offer_src = best_src;
            st_next.offer_lvl = best_lvl;
            st_next.vector = VIPC_VEC_BASE + {8'h00, best_src, 3'b000};
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // reset is the non-maskable source and overrides everything
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= VIPC_STATE_RST;
        end
        else if (aclken)
        begin
            st_reg <= st_next;
        end
    end

endmodule : vipc_ctrl

/* hw/vipc_pkg.sv */
// constants and state types shared by the vectored interrupt controller
package vipc_pkg;

    // ----------------------------------------------------------------
    // source map
    // ----------------------------------------------------------------
    localparam int VIPC_NSRC = 24;
    localparam int VIPC_NGRP = 6;
    localparam int VIPC_NEXT = 5;
    localparam logic [23:0] VIPC_EXT_MASK = 24'h000863;
    localparam logic [23:0] VIPC_NO_SRC_MASK = 24'h800080;
    localparam logic [15:0] VIPC_VEC_BASE = 16'h0003;
    localparam logic [15:0] VIPC_NMI_VEC = 16'h0000;

    // ----------------------------------------------------------------
    // register indices and byte addresses (index times four)
    // ----------------------------------------------------------------
    localparam logic [7:0] VIPC_IDX_EN0 = 8'ha8;
    localparam logic [7:0] VIPC_IDX_EN1 = 8'ha9;
    localparam logic [7:0] VIPC_IDX_EN2 = 8'haa;
    localparam logic [7:0] VIPC_IDX_EN3 = 8'hab;
    localparam logic [7:0] VIPC_IDX_LVL_LO = 8'hb8;
    localparam logic [7:0] VIPC_IDX_LVL_HI = 8'hf8;
    localparam logic [7:0] VIPC_IDX_PEND0 = 8'hc0;
    localparam logic [7:0] VIPC_IDX_SEL0_LO = 8'ha4;
    localparam logic [7:0] VIPC_IDX_SEL0_HI = 8'ha5;
    localparam logic [7:0] VIPC_IDX_PEND1 = 8'ha6;
    localparam logic [7:0] VIPC_IDX_SEL1 = 8'ha7;
    localparam logic [11:0] VIPC_ADDR_EN0 = {2'b00, VIPC_IDX_EN0, 2'b00};
    localparam logic [11:0] VIPC_ADDR_EN1 = {2'b00, VIPC_IDX_EN1, 2'b00};
    localparam logic [11:0] VIPC_ADDR_EN2 = {2'b00, VIPC_IDX_EN2, 2'b00};
    localparam logic [11:0] VIPC_ADDR_EN3 = {2'b00, VIPC_IDX_EN3, 2'b00};
    localparam logic [11:0] VIPC_ADDR_LVL_LO = {2'b00, VIPC_IDX_LVL_LO, 2'b00};
    localparam logic [11:0] VIPC_ADDR_LVL_HI = {2'b00, VIPC_IDX_LVL_HI, 2'b00};
    localparam logic [11:0] VIPC_ADDR_PEND0 = {2'b00, VIPC_IDX_PEND0, 2'b00};
    localparam logic [11:0] VIPC_ADDR_SEL0_LO = {2'b00, VIPC_IDX_SEL0_LO, 2'b00};
    localparam logic [11:0] VIPC_ADDR_SEL0_HI = {2'b00, VIPC_IDX_SEL0_HI, 2'b00};
    localparam logic [11:0] VIPC_ADDR_PEND1 = {2'b00, VIPC_IDX_PEND1, 2'b00};
    localparam logic [11:0] VIPC_ADDR_SEL1 = {2'b00, VIPC_IDX_SEL1, 2'b00};
    localparam logic [11:0] VIPC_ADDR_TRIG = 12'h400;
    localparam logic [11:0] VIPC_ADDR_STAT = 12'h404;
    localparam logic [11:0] VIPC_ADDR_FLAGS = 12'h408;

    // ----------------------------------------------------------------
    // writable bit masks, reset value, bus answers
    // ----------------------------------------------------------------
    localparam logic [7:0] VIPC_MASK_EN0 = 8'hbf;
    localparam logic [7:0] VIPC_MASK_EN = 8'h3f;
    localparam logic [7:0] VIPC_MASK_SEL0 = 8'h0f;
    localparam logic [7:0] VIPC_MASK_SEL1 = 8'h03;
    localparam int VIPC_GATE_BIT = 7;
    localparam logic [7:0] VIPC_REG_RST = 8'h00;
    localparam logic [1:0] VIPC_RESP_OKAY = 2'b00;
    localparam logic [1:0] VIPC_RESP_SLVERR = 2'b10;

    typedef enum logic {VIPC_WR_IDLE, VIPC_WR_RESP} vipc_wr_st_t;
    typedef enum logic {VIPC_RD_IDLE, VIPC_RD_DATA} vipc_rd_st_t;

    typedef struct packed {
        logic [7:0] en0;
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [7:0] lvl_lo;
        logic [7:0] lvl_hi;
        logic [7:0] sel0_lo;
        logic [7:0] sel0_hi;
        logic [7:0] sel1;
        logic [23:0] trig;
        logic [23:0] flag;
        logic [23:0] prev_req;
        logic [4:0] ext_prev;
        logic [3:0] in_service;
        logic hold;
        logic offer;
        logic [4:0] offer_src;
        logic [1:0] offer_lvl;
        logic [15:0] vector;
        vipc_wr_st_t wr;
        logic [1:0] bresp;
        vipc_rd_st_t rd;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } vipc_state_t;

    localparam vipc_state_t VIPC_STATE_RST = '0;

    // slot of an external source in the pin vector, or -1
    function automatic int vipc_ext_slot(input int src);
        case (src)
            0: return 0;
            1: return 1;
            5: return 2;
            6: return 3;
            11: return 4;
            default: return -1;
        endcase
    endfunction : vipc_ext_slot

endpackage : vipc_pkg

/* tb/tb_top.sv */
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module tb_top;
    import vipc_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, power_ctrl_wr, irq_ack, return_from_isr, irq_req;
    logic stop_idle_release, ret_cmd;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [23:0] src_req;
    logic [4:0] ext_pin;
    logic [15:0] irq_vector, got_vec;
    logic [3:0] ack_wait;
    int n_ack, mismatches, check_count, seen;
    vipc_ctrl i_vipc_ctrl (.aclk, .aresetn, .aclken(1'b1), .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_req, .ext_pin,
        .power_ctrl_wr, .irq_ack, .return_from_isr, .irq_req, .irq_vector,
        .stop_idle_release);
    vipc_core_model i_vipc_core_model (.aclk, .irq_req, .irq_vector, .ack_wait,
        .ret_cmd, .irq_ack, .return_from_isr, .got_vec, .n_ack);
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
        check_count++;
        if (seen_v !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen_v);
        end
    endtask : check
    // k: 0 awready, 1 bvalid, 2 arready, 3 rvalid, 4 new ack from the core
    task automatic hs(input int k);
        int n;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (n > 100)
            begin
                mismatches++;
                summarize();
            end
        end
        while ((k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid
            : k == 2 ? s_axi_arready : k == 3 ? s_axi_rvalid : n_ack > seen) !== 1'b1);
    endtask : hs
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        hs(0);
        {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
        hs(1);
        s_axi_bready <= 1'b0;
        check("bresp", 32'(s_axi_bresp), 32'h0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        hs(2);
        s_axi_arvalid <= 1'b0;
        hs(3);
        s_axi_rready <= 1'b0;
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        if (er == VIPC_RESP_OKAY)
            check("rdata", s_axi_rdata, ed);
    endtask : rd
    task automatic serve(input logic [15:0] v, input logic [7:0] reen);
        hs(4);
        seen++;
        check("vector", {16'h0, got_vec}, {16'h0, v});
        if (reen != 8'h00)
        begin
            wr(VIPC_ADDR_EN0, {24'h0, reen});
            repeat (8) @(posedge aclk);
            check("nested", 32'(n_ack), 32'(seen));
        end
    endtask : serve
    task automatic ret();
        ret_cmd <= 1'b1;
        @(posedge aclk);
        ret_cmd <= 1'b0;
    endtask : ret
    task automatic t_reset();
        logic [11:0] regs [11] = '{VIPC_ADDR_EN0, VIPC_ADDR_EN1, VIPC_ADDR_EN2,
            VIPC_ADDR_EN3, VIPC_ADDR_LVL_LO, VIPC_ADDR_LVL_HI, VIPC_ADDR_PEND0,
            VIPC_ADDR_SEL0_LO, VIPC_ADDR_SEL0_HI, VIPC_ADDR_PEND1, VIPC_ADDR_SEL1};
        foreach (regs[i])
            rd(regs[i], 32'h0, VIPC_RESP_OKAY);
        rd(12'h010, 32'h0, VIPC_RESP_SLVERR);
        wr(VIPC_ADDR_EN1, 32'hff);
        rd(VIPC_ADDR_EN1, 32'h3f, VIPC_RESP_OKAY);
    endtask : t_reset
    task automatic t_single();
        int n;
        ack_wait <= 4'h3;
        wr(VIPC_ADDR_EN0, 32'h84);
        src_req <= 24'h000004;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (irq_req !== 1'b1 && n < 20);
        src_req <= 24'h0;
        check("latency", 32'(n), 32'd3);
        check("release", {31'h0, stop_idle_release}, 32'h1);
        serve(16'h0013, 8'h00);
        rd(VIPC_ADDR_EN0, 32'h04, VIPC_RESP_OKAY);
        rd(VIPC_ADDR_FLAGS, 32'h0, VIPC_RESP_OKAY);
        ret();
        rd(VIPC_ADDR_EN0, 32'h84, VIPC_RESP_OKAY);
    endtask : t_single
    // edge mode serves each flag once, so the order shows
    task automatic t_prio();
        ack_wait <= 4'h0;
        wr(VIPC_ADDR_EN0, 32'h1c);
        wr(VIPC_ADDR_EN1, 32'h08);
        wr(VIPC_ADDR_LVL_LO, 32'h10);
        wr(VIPC_ADDR_LVL_HI, 32'h08);
        wr(VIPC_ADDR_TRIG, 32'h21c);
        power_ctrl_wr <= 1'b1;
        src_req <= 24'h00021c;
        @(posedge aclk);
        power_ctrl_wr <= 1'b0;
        wr(VIPC_ADDR_EN0, 32'h9c);
        serve(16'h001b, 8'h9c);
        ret();
        serve(16'h004b, 8'h00);
        ret();
        serve(16'h0023, 8'h00);
        ret();
        serve(16'h0013, 8'h00);
        ret();
        src_req <= 24'h0;
    endtask : t_prio
    task automatic t_ext();
        wr(VIPC_ADDR_EN0, 32'h01);
        wr(VIPC_ADDR_SEL0_LO, 32'h01);
        ext_pin <= 5'h01;
        repeat (4) @(posedge aclk);
        rd(VIPC_ADDR_PEND0, 32'h01, VIPC_RESP_OKAY);
        check("release", {31'h0, stop_idle_release}, 32'h1);
        check("gated", 32'(n_ack), 32'(seen));
        wr(VIPC_ADDR_PEND0, 32'h00);
        ext_pin <= 5'h00;
        repeat (2) @(posedge aclk);
        rd(VIPC_ADDR_PEND0, 32'h00, VIPC_RESP_OKAY);
        wr(VIPC_ADDR_EN0, 32'h81);
        ext_pin <= 5'h01;
        serve(16'h0003, 8'h00);
        ret();
    endtask : t_ext
    task automatic t_empty();
        wr(VIPC_ADDR_EN1, 32'h02);
        wr(VIPC_ADDR_EN3, 32'h20);
        src_req <= 24'h800080;
        repeat (8) @(posedge aclk);
        check("empty", 32'(n_ack), 32'(seen));
        rd(VIPC_ADDR_FLAGS, 32'h0, VIPC_RESP_OKAY);
        src_req <= 24'h0;
    endtask : t_empty
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, power_ctrl_wr, ret_cmd, ack_wait, src_req, ext_pin} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_single();
        t_prio();
        t_ext();
        t_empty();
        summarize();
    end
endmodule : tb_top

/* tb/vipc_chk.sv */
// port assertions for the vectored interrupt controller
`timescale 1ns/1ps
module vipc_chk
    import vipc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic power_ctrl_wr,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic stop_idle_release
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic hold;
    // enable register 0 writes and power writes block new offers for two cycles
    assign hold = power_ctrl_wr || (s_axi_awvalid && s_axi_awready
        && s_axi_awaddr == VIPC_ADDR_EN0);
    ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req [*2])
        else $error("offer kept after ack");
    vec_hold_a: assert property (irq_req && !irq_ack |=> !irq_req || $stable(irq_vector))
        else $error("vector moved while offered");
    vec_form_a: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h00bb)
        else $error("vector outside table");
    empty_src_a: assert property (irq_req |-> irq_vector != 16'h003b && irq_vector != 16'h00bb)
        else $error("vector of an empty source");
    write_hold_a: assert property (hold |=> !$rose(irq_req) ##1 !$rose(irq_req))
        else $error("offer during held write");
    wake_first_a: assert property ($rose(irq_req) |-> $past(stop_idle_release))
        else $error("offer without release");
    rst_quiet_a: assert property (disable iff (1'b0)
        !aresetn |=> !irq_req && !stop_idle_release && !s_axi_bvalid)
        else $error("outputs active after reset");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    cover property (irq_req && irq_ack);
    cover property (hold);
    cover property ($rose(irq_req));
endmodule : vipc_chk

bind vipc_ctrl vipc_chk i_vipc_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .power_ctrl_wr, .irq_ack, .irq_req, .irq_vector, .stop_idle_release);

/* tb/vipc_core_model.sv */
// behavioural core: takes offered vectors and returns from service on command
`timescale 1ns/1ps
module vipc_core_model (
    input wire logic aclk,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [3:0] ack_wait,
    input wire logic ret_cmd,
    output logic irq_ack,
    output logic return_from_isr,
    output logic [15:0] got_vec,
    output int n_ack
);
    logic [3:0] cnt;
    initial
    begin
        {irq_ack, return_from_isr, got_vec, cnt} = '0;
        n_ack = 0;
    end
    // ack_wait stalls give both prompt and slow acceptance
    always @(posedge aclk)
    begin
        irq_ack <= 1'b0;
        return_from_isr <= ret_cmd;
        if (irq_req && !irq_ack)
        begin
            if (cnt >= ack_wait)
            begin
                irq_ack <= 1'b1;
                got_vec <= irq_vector;
                n_ack <= n_ack + 1;
                cnt <= '0;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule : vipc_core_model
